// ---- src/pfcp_defs.vh ----
`ifndef PFCP_DEFS_VH
`define PFCP_DEFS_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PFCP_CW        16
`define PFCP_AW        12
`define PFCP_TW        24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PFCP_RATIO_MSB 8
`define PFCP_RATIO_LSB 6
`define PFCP_AC_OVR_BIT 8

// ----------------------------------------------------------------
// Ratio codes
// ----------------------------------------------------------------
`define PFCP_RATIO_2   3'h2
`define PFCP_RATIO_3   3'h3
`define PFCP_RATIO_4   3'h4
`define PFCP_RATIO_5   3'h5
`define PFCP_DIV_3     16'h0003
`define PFCP_DIV_5     16'h0005

// ----------------------------------------------------------------
// Constants and timing
// ----------------------------------------------------------------
`define PFCP_ZERO16    16'h0000
`define PFCP_ONE16     16'h0001
`define PFCP_ZERO12    12'h000
`define PFCP_FULL12    12'hfff
`define PFCP_ZERO24    24'h000000
`define PFCP_ONE24     24'h000001
`define PFCP_CLK_KHZ   20000
`define PFCP_PEAK_MS   100

`endif

// ---- src/pfcp_persist.v ----
`include "pfcp_defs.vh"

// ----------------------------------------------------------------
// Flag rises once the condition has held
// for at least the threshold number of clock cycles.
// ----------------------------------------------------------------
module pfcp_persist
(
    // Clock and reset.
    input  wire                   clk_i,
    input  wire                   rstn_i,
    // Condition and threshold.
    input  wire                   cond_i,
    input  wire [`PFCP_TW-1:0]    thresh_i,
    // Qualified flag.
    output wire                   flag_o
);

    reg  [`PFCP_TW-1:0] cnt_q;
    reg                 flag_q;

    // Count saturates and restarts on any break.
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_q  <= `PFCP_ZERO24;
            flag_q <= 1'b0;
        end
        else if (!cond_i)
        begin
            cnt_q  <= `PFCP_ZERO24;
            flag_q <= 1'b0;
        end
        else if (cnt_q >= thresh_i)
        begin
            flag_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + `PFCP_ONE24;
        end
    end

    assign flag_o = flag_q;

endmodule

// ---- src/pfcp_top.v ----
`include "pfcp_defs.vh"

// Notes on behaviour
// - Output high while latched duty exceeds carrier, low while below.
// - PFC period is motor period divided by ratio 2 to 5 in jumper bits 8:6; other codes keep the motor period.
// - Carrier setup taken at first configure, later only at pre-charge end.
// - One sync per PFC period; duty latched there and held until next.
// - Current sample at pulse middle plus programmed sample delay.
// - Gate shutdown disables the output regardless of anything else.
// - Switching only when enable is 1 and bus blanking flag is 0.
// - Bus versus AC voltage compared once every motor PWM cycle.
// - AC above bus minus offset sets blanking for at least minimum time.
// - Current above reference plus gap at cycle start suppresses cycle.
// - In a current blanked cycle sample at centre of the cycle.
// - Bus, current, AC and peak feedback presented as 12-bit counts.
// - AC peak is maximum AC voltage over the last 100 ms window.
// - AC voltage sampled at the start of each PFC cycle.
// - AC feedback is the rectified absolute value of AC input.
// - Fault bit 0 set while abnormal, cleared after recovery time normal.
// - Under bit 1 set after AC below level for under time.
// - Over bit 2 set after AC above level for over time.
// - Secondary bit 8 low keeps PFC off while fault flag is set.
// - Active output is 1 while switching is enabled.
module pfcp_top
#(
    parameter PEAK_WIN_CYC = `PFCP_PEAK_MS * `PFCP_CLK_KHZ
)
(
    // Clock and reset.
    input  wire                   clk_i,
    input  wire                   rstn_i,
    // Carrier configuration.
    input  wire [`PFCP_CW-1:0]    motor_period_config_i,
    input  wire [`PFCP_CW-1:0]    control_jumper_word_i,
    input  wire [`PFCP_CW-1:0]    secondary_jumper_word_i,
    input  wire [`PFCP_CW-1:0]    current_sample_delay_i,
    input  wire                   cfg_load_i,
    input  wire                   precharge_done_i,
    // Control loop commands.
    input  wire [`PFCP_CW-1:0]    duty_command_i,
    input  wire [`PFCP_AW-1:0]    current_ref_i,
    input  wire                   pfc_enable_in_i,
    input  wire                   gate_shutdown_i,
    // Blanking settings.
    input  wire [`PFCP_AW-1:0]    blank_offset_i,
    input  wire [`PFCP_CW-1:0]    min_blank_time_i,
    input  wire [`PFCP_AW-1:0]    current_blank_gap_i,
    // AC status settings.
    input  wire [`PFCP_AW-1:0]    ac_under_level_i,
    input  wire [`PFCP_TW-1:0]    ac_under_time_i,
    input  wire [`PFCP_AW-1:0]    ac_over_level_i,
    input  wire [`PFCP_TW-1:0]    ac_over_time_i,
    input  wire [`PFCP_TW-1:0]    ac_recover_time_i,
    // Converter results.
    input  wire [`PFCP_AW-1:0]    bus_voltage_raw_i,
    input  wire [`PFCP_AW-1:0]    current_raw_i,
    input  wire [`PFCP_AW:0]      ac_voltage_raw_i,
    // Gate drive and status.
    output wire                   pfc_gate_o,
    output wire                   pfc_output_active_o,
    output wire                   bus_blank_status_o,
    output wire                   sync_o,
    output wire                   current_sample_o,
    output wire                   ac_sample_o,
    output wire [2:0]             ac_condition_word_o,
    // Feedback values.
    output wire [`PFCP_AW-1:0]    bus_voltage_out_o,
    output wire [`PFCP_AW-1:0]    input_current_sample_o,
    output wire [`PFCP_AW-1:0]    ac_voltage_o,
    output wire [`PFCP_AW-1:0]    ac_peak_voltage_o
);

    localparam [`PFCP_TW-1:0] PEAK_LAST = PEAK_WIN_CYC - 1;

    reg                 cfg_done_q;
    reg  [`PFCP_CW-1:0] motor_period_q;
    reg  [`PFCP_CW-1:0] pfc_period_q;
    reg  [`PFCP_CW-1:0] pfc_div_d;
    reg  [`PFCP_CW-1:0] motor_cnt_q;
    reg  [`PFCP_CW-1:0] carrier_q;
    reg  [`PFCP_CW-1:0] duty_q;
    reg  [`PFCP_CW:0]   sample_pt_q;
    reg                 cur_blank_q;
    reg                 vblank_q;
    reg  [`PFCP_CW-1:0] blank_tmr_q;
    reg                 gate_q;
    reg                 active_q;
    reg                 sync_q;
    reg                 cur_smp_q;
    reg                 ac_smp_q;
    reg  [`PFCP_AW-1:0] bus_q;
    reg  [`PFCP_AW-1:0] cur_q;
    reg  [`PFCP_AW-1:0] ac_q;
    reg  [`PFCP_AW-1:0] peak_q;
    reg  [`PFCP_AW-1:0] run_max_q;
    reg  [`PFCP_TW-1:0] win_cnt_q;
    reg                 fault_q;

    wire [2:0]          ratio;
    wire                cfg_take;
    wire [`PFCP_CW-1:0] motor_last;
    wire [`PFCP_CW-1:0] pfc_last;
    wire                motor_tick;
    wire                sync;
    wire [`PFCP_AW:0]   ac_mag;
    wire [`PFCP_AW-1:0] ac_abs;
    wire                vcond;
    wire                icond;
    wire                en_now;
    wire                under_flag;
    wire                over_flag;
    wire                normal_ok;

    // ------------------------------------------------------------
    // Carrier configuration
    // ------------------------------------------------------------

    // Ratio field picks the divider.
    assign ratio = control_jumper_word_i[`PFCP_RATIO_MSB:`PFCP_RATIO_LSB];

    always @*
    begin
        case (ratio)
            `PFCP_RATIO_2: pfc_div_d = motor_period_config_i >> 1;
            `PFCP_RATIO_3: pfc_div_d = motor_period_config_i / `PFCP_DIV_3;
            `PFCP_RATIO_4: pfc_div_d = motor_period_config_i >> 2;
            `PFCP_RATIO_5: pfc_div_d = motor_period_config_i / `PFCP_DIV_5;
            default:       pfc_div_d = motor_period_config_i;
        endcase
    end

    // First setup once, then only at pre-charge end.
    assign cfg_take = cfg_done_q ? precharge_done_i : cfg_load_i;

    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cfg_done_q     <= 1'b0;
            motor_period_q <= `PFCP_ZERO16;
            pfc_period_q   <= `PFCP_ZERO16;
        end
        else if (cfg_take)
        begin
            cfg_done_q     <= 1'b1;
            motor_period_q <= motor_period_config_i;
            pfc_period_q   <= pfc_div_d;
        end
    end

    // ------------------------------------------------------------
    // Motor and PFC carriers
    // ------------------------------------------------------------

    // A zero period ticks every clock.
    assign motor_last = (motor_period_q == `PFCP_ZERO16) ? `PFCP_ZERO16 :
                        motor_period_q - `PFCP_ONE16;
    assign pfc_last   = (pfc_period_q == `PFCP_ZERO16) ? `PFCP_ZERO16 :
                        pfc_period_q - `PFCP_ONE16;
    assign motor_tick = cfg_done_q && (motor_cnt_q >= motor_last);
    assign sync       = cfg_done_q && (carrier_q >= pfc_last);

    // Both counters restart on a new setup.
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            motor_cnt_q <= `PFCP_ZERO16;
            carrier_q   <= `PFCP_ZERO16;
        end
        else
        begin
            if (cfg_take || motor_tick)
                motor_cnt_q <= `PFCP_ZERO16;
            else if (cfg_done_q)
                motor_cnt_q <= motor_cnt_q + `PFCP_ONE16;
            if (cfg_take || sync)
                carrier_q <= `PFCP_ZERO16;
            else if (cfg_done_q)
                carrier_q <= carrier_q + `PFCP_ONE16;
        end
    end

    // ------------------------------------------------------------
    // Per-cycle latch and current blanking
    // ------------------------------------------------------------

    assign icond = {1'b0, current_raw_i} >
                   ({1'b0, current_ref_i} + {1'b0, current_blank_gap_i});

    // Decided at sync, before the sample point is placed.
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            duty_q      <= `PFCP_ZERO16;
            cur_blank_q <= 1'b0;
            sample_pt_q <= {1'b0, `PFCP_ZERO16};
        end
        else if (sync)
        begin
            duty_q      <= duty_command_i;
            cur_blank_q <= icond;
            if (icond)
                sample_pt_q <= {2'b00, pfc_period_q[`PFCP_CW-1:1]};
            else
                sample_pt_q <= {2'b00, duty_command_i[`PFCP_CW-1:1]} +
                               {1'b0, current_sample_delay_i};
        end
    end

    // ------------------------------------------------------------
    // Voltage blanking
    // ------------------------------------------------------------

    // A sum, so an offset above the bus cannot wrap.
    assign vcond = ({1'b0, ac_q} + {1'b0, blank_offset_i}) >
                   {1'b0, bus_voltage_raw_i};

    // Flag holds for the minimum time from its rise.
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            vblank_q    <= 1'b0;
            blank_tmr_q <= `PFCP_ZERO16;
        end
        else if (motor_tick && vcond && !vblank_q)
        begin
            vblank_q    <= 1'b1;
            blank_tmr_q <= min_blank_time_i;
        end
        else
        begin
            if (blank_tmr_q != `PFCP_ZERO16)
                blank_tmr_q <= blank_tmr_q - `PFCP_ONE16;
            if (motor_tick && !vcond && blank_tmr_q == `PFCP_ZERO16)
                vblank_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Switching enable and gate output
    // ------------------------------------------------------------

    // All enable conditions combine here.
    assign en_now = pfc_enable_in_i && !vblank_q &&
                    !gate_shutdown_i &&
                    !(fault_q &&
                      !secondary_jumper_word_i[`PFCP_AC_OVR_BIT]);

    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            gate_q   <= 1'b0;
            active_q <= 1'b0;
        end
        else
        begin
            gate_q   <= en_now && cfg_done_q && !cur_blank_q &&
                        (duty_q > carrier_q);
            active_q <= en_now;
        end
    end

    // Shutdown also gates the flop output so the kill is immediate.
    assign pfc_gate_o = gate_q && !gate_shutdown_i;

    // ------------------------------------------------------------
    // Sensing and sample strobes
    // ------------------------------------------------------------

    // Rectify the AC sample, saturating at 12 bits.
    assign ac_mag = ac_voltage_raw_i[`PFCP_AW] ?
                    (~ac_voltage_raw_i + {`PFCP_ZERO12, 1'b1}) :
                    ac_voltage_raw_i;
    assign ac_abs = ac_mag[`PFCP_AW] ? `PFCP_FULL12 :
                    ac_mag[`PFCP_AW-1:0];

    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync_q    <= 1'b0;
            cur_smp_q <= 1'b0;
            ac_smp_q  <= 1'b0;
            bus_q     <= `PFCP_ZERO12;
            cur_q     <= `PFCP_ZERO12;
            ac_q      <= `PFCP_ZERO12;
        end
        else
        begin
            sync_q    <= sync;
            ac_smp_q  <= sync;
            cur_smp_q <= cfg_done_q && !sample_pt_q[`PFCP_CW] &&
                         (carrier_q == sample_pt_q[`PFCP_CW-1:0]);
            if (motor_tick)
                bus_q <= bus_voltage_raw_i;
            if (sync)
                ac_q <= ac_abs;
            if (cfg_done_q && !sample_pt_q[`PFCP_CW] &&
                carrier_q == sample_pt_q[`PFCP_CW-1:0])
                cur_q <= current_raw_i;
        end
    end

    // ------------------------------------------------------------
    // Peak over a fixed window
    // ------------------------------------------------------------

    // Running maximum is published at each window end.
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            win_cnt_q <= `PFCP_ZERO24;
            run_max_q <= `PFCP_ZERO12;
            peak_q    <= `PFCP_ZERO12;
        end
        else if (win_cnt_q >= PEAK_LAST)
        begin
            win_cnt_q <= `PFCP_ZERO24;
            peak_q    <= (ac_q > run_max_q) ? ac_q : run_max_q;
            run_max_q <= ac_q;
        end
        else
        begin
            win_cnt_q <= win_cnt_q + `PFCP_ONE24;
            if (ac_q > run_max_q)
                run_max_q <= ac_q;
        end
    end

    // ------------------------------------------------------------
    // AC condition flags
    // ------------------------------------------------------------

    pfcp_persist u_under
    (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .cond_i   (peak_q < ac_under_level_i),
        .thresh_i (ac_under_time_i),
        .flag_o   (under_flag)
    );

    pfcp_persist u_over
    (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .cond_i   (peak_q > ac_over_level_i),
        .thresh_i (ac_over_time_i),
        .flag_o   (over_flag)
    );

    pfcp_persist u_recover
    (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .cond_i   (!under_flag && !over_flag),
        .thresh_i (ac_recover_time_i),
        .flag_o   (normal_ok)
    );

    // Abnormal input sets the fault; only a qualified recovery clears.
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            fault_q <= 1'b0;
        else if (under_flag || over_flag)
            fault_q <= 1'b1;
        else if (normal_ok)
            fault_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    assign pfc_output_active_o = active_q;
    assign bus_blank_status_o  = vblank_q;
    assign sync_o              = sync_q;
    assign current_sample_o    = cur_smp_q;
    assign ac_sample_o         = ac_smp_q;
    assign ac_condition_word_o = {over_flag, under_flag, fault_q};
    assign bus_voltage_out_o   = bus_q;
    assign input_current_sample_o = cur_q;
    assign ac_voltage_o        = ac_q;
    assign ac_peak_voltage_o   = peak_q;

endmodule

// ---- bench/pfcp_checker.sv ----
// ------------------------------------------------------------
// Port checker for the PFC PWM block.
// ------------------------------------------------------------
module pfcp_checker
(
    // Clock and reset.
    input wire        clk_i,
    input wire        rstn_i,
    // Watched inputs.
    input wire [15:0] secondary_jumper_word_i,
    input wire [15:0] min_blank_time_i,
    input wire        pfc_enable_in_i,
    input wire        gate_shutdown_i,
    input wire [11:0] current_raw_i,
    input wire [12:0] ac_voltage_raw_i,
    // Watched outputs.
    input wire        pfc_gate_o,
    input wire        pfc_output_active_o,
    input wire        bus_blank_status_o,
    input wire        sync_o,
    input wire        current_sample_o,
    input wire        ac_sample_o,
    input wire [2:0]  ac_condition_word_o,
    input wire [11:0] input_current_sample_o,
    input wire [11:0] ac_voltage_o
);
    // Magnitude of the raw AC sample.
    wire [12:0]  ac_mag = ac_voltage_raw_i[12] ?
                          13'h0000 - ac_voltage_raw_i : ac_voltage_raw_i;
    logic [15:0] blank_run_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Unbroken cycles of blanking.
    always_ff @(posedge clk_i or negedge rstn_i)
        if (!rstn_i)
            blank_run_q <= 16'h0000;
        else if (bus_blank_status_o)
            blank_run_q <= blank_run_q + 16'h0001;
        else
            blank_run_q <= 16'h0000;

    // Enable dropped while active.
    sequence s_enable_drop;
        pfc_output_active_o ##1 !pfc_enable_in_i;
    endsequence

    // AC fault with lockout jumper clear.
    sequence s_fault_lock;
        ac_condition_word_o[0] && !secondary_jumper_word_i[8];
    endsequence

    a_gate_kill: assert property (gate_shutdown_i |-> !pfc_gate_o)
        else $error("gate high during shutdown");
    a_gate_needs_on: assert property (pfc_gate_o |-> pfc_output_active_o)
        else $error("gate high while inactive");
    a_enable_drop: assert property (s_enable_drop |=> !pfc_output_active_o)
        else $error("active after enable dropped");
    a_blank_holds_off: assert property
        (bus_blank_status_o |=> !pfc_output_active_o)
        else $error("active while blanked");
    a_fault_lockout: assert property (s_fault_lock |=> !pfc_output_active_o)
        else $error("active while AC fault locks out");
    a_fault_follows: assert property
        (|ac_condition_word_o[2:1] |=> ac_condition_word_o[0])
        else $error("fault flag missing");
    a_sync_single: assert property (sync_o |=> !sync_o)
        else $error("sync longer than one cycle");
    a_ac_with_sync: assert property (sync_o == ac_sample_o)
        else $error("AC sample not at cycle start");
    a_ac_rectified: assert property
        (ac_sample_o |-> {1'b0, ac_voltage_o} == $past(ac_mag))
        else $error("AC feedback not rectified");
    a_cur_capture: assert property
        (current_sample_o |-> input_current_sample_o == $past(current_raw_i))
        else $error("current feedback not captured");
    a_blank_min_time: assert property
        ($fell(bus_blank_status_o) |-> blank_run_q >= min_blank_time_i)
        else $error("blanking released early");
endmodule

bind pfcp_top pfcp_checker u_chk (.*);

// ---- bench/pfcp_loop_model.sv ----
// ------------------------------------------------------------
// Control loop and gate driver stand-in.
// ------------------------------------------------------------
module pfcp_loop_model
(
    // Clock and reset.
    input  logic        clk_i,
    input  logic        rstn_i,
    // Bench requests and block outputs.
    input  logic [15:0] duty_set_i,
    input  logic [11:0] ref_set_i,
    input  logic        pfc_gate_i,
    input  logic        sync_i,
    // Commands to the block and gate-on count per period.
    output logic [15:0] duty_command_o,
    output logic [11:0] current_ref_o,
    output logic [15:0] on_count_o
);
    logic [15:0] on_run_q;
    wire  [15:0] on_sum = on_run_q + {15'h0000, pfc_gate_i};

    // Commands follow each edge; gate-on cycles are totalled per period.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            duty_command_o <= 16'h0000;
            current_ref_o  <= 12'h000;
            on_run_q       <= 16'h0000;
            on_count_o     <= 16'h0000;
        end
        else
        begin
            duty_command_o <= duty_set_i;
            current_ref_o  <= ref_set_i;
            on_run_q       <= sync_i ? 16'h0000 : on_sum;
            if (sync_i)
                on_count_o <= on_sum;
        end
    end
endmodule

// ---- bench/pfcp_top_tb.sv ----
// ------------------------------------------------------------
// Testbench for the PFC PWM block.
// ------------------------------------------------------------
module pfcp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cfg_load = 1'b0;
    logic        precharge = 1'b0;
    logic        enable = 1'b1;
    logic        shutdown = 1'b0;
    logic [15:0] jumper = 16'h00c0;
    logic [15:0] second = 16'h0100;
    logic [15:0] delay = 16'h0000;
    logic [15:0] duty_set = 16'h0000;
    logic [11:0] ref_set = 12'h800;
    logic [11:0] gap = 12'h000;
    logic [11:0] offset = 12'h000;
    logic [11:0] uv_lvl = 12'h000;
    logic [11:0] ov_lvl = 12'hfff;
    logic [11:0] cur_raw = 12'h123;
    logic [12:0] ac_raw = 13'h0200;
    logic [11:0] bus = 12'h300;
    logic [15:0] mper = 16'h003c;
    logic [15:0] ratio_exp [8] = '{16'h003c, 16'h003c, 16'h001e, 16'h0014,
                                  16'h000f, 16'h000c, 16'h003c, 16'h003c};
    logic [15:0] duty_tab [6] = '{16'h0, 16'h1, 16'ha, 16'h13, 16'h14, 16'h19};
    logic [15:0] duty_exp [6] = '{16'h0, 16'h1, 16'ha, 16'h13, 16'h14, 16'h14};
    wire  [15:0] duty, on_count;
    wire  [11:0] cur_ref, bus_o, cur_o, acv, peak;
    wire         gate, active, blank, sync, csamp, asamp;
    wire  [2:0]  acw;
    int          failures = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          n;

    // Blank 100, under/over 50, recovery 40 cycles.
    pfcp_top #(.PEAK_WIN_CYC(200)) DUT
    (
        .clk_i(clk), .rstn_i(rstn), .motor_period_config_i(mper),
        .control_jumper_word_i(jumper), .secondary_jumper_word_i(second),
        .current_sample_delay_i(delay), .cfg_load_i(cfg_load),
        .precharge_done_i(precharge), .duty_command_i(duty),
        .current_ref_i(cur_ref), .pfc_enable_in_i(enable),
        .gate_shutdown_i(shutdown), .blank_offset_i(offset),
        .min_blank_time_i(16'h0064), .current_blank_gap_i(gap),
        .ac_under_level_i(uv_lvl), .ac_under_time_i(24'h000032),
        .ac_over_level_i(ov_lvl), .ac_over_time_i(24'h000032),
        .ac_recover_time_i(24'h000028), .bus_voltage_raw_i(bus),
        .current_raw_i(cur_raw), .ac_voltage_raw_i(ac_raw),
        .pfc_gate_o(gate), .pfc_output_active_o(active),
        .bus_blank_status_o(blank), .sync_o(sync),
        .current_sample_o(csamp), .ac_sample_o(asamp),
        .ac_condition_word_o(acw), .bus_voltage_out_o(bus_o),
        .input_current_sample_o(cur_o), .ac_voltage_o(acv),
        .ac_peak_voltage_o(peak)
    );

    pfcp_loop_model u_loop
    (
        .clk_i(clk), .rstn_i(rstn), .duty_set_i(duty_set),
        .ref_set_i(ref_set), .pfc_gate_i(gate), .sync_i(sync),
        .duty_command_o(duty), .current_ref_o(cur_ref),
        .on_count_o(on_count)
    );

    // Clock and cycle ceiling.
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            report_and_stop();
        end
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #5;
    endtask

    task automatic check_val(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return sync;
            1: return csamp;
            2: return blank;
            3: return !blank;
            4: return acw[2];
            5: return acw[1];
            default: return acw == 3'h0;
        endcase
    endfunction

    // Bounded wait for the chosen event.
    task automatic wait_on(input int sel, input int lim, output int k);
        k = 0;
        do
        begin
            tick(1);
            k++;
        end
        while (pick(sel) !== 1'b1 && k < lim);
    endtask

    task automatic pulse(input logic pre);
        cfg_load = !pre;
        precharge = pre;
        tick(1);
        cfg_load = 1'b0;
        precharge = 1'b0;
    endtask

    task automatic period_is(input logic [15:0] exp);
        repeat (2) wait_on(0, 400, n);
        check_val("period", exp, n);
    endtask

    task automatic run_duty(input logic [15:0] d, input logic [15:0] exp);
        duty_set = d;
        repeat (3) wait_on(0, 400, n);
        tick(1);
        check_val("on_cycles", exp, on_count);
    endtask

    task automatic report_and_stop();
        $display("Checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        tick(6);
        rstn = 1'b1;
        check_val("gate", 1'b0, gate);
        check_val("active", 1'b0, active);
        pulse(1'b0);
        period_is(16'h0014);
        jumper = 16'h0080;
        pulse(1'b0);
        period_is(16'h0014);
        for (int i = 0; i < 8; i++)
        begin
            jumper = 16'(i) << 6;
            pulse(1'b1);
            period_is(ratio_exp[i]);
        end
        jumper = 16'h00c0;
        pulse(1'b1);
        period_is(16'h0014);
        for (int i = 0; i < 6; i++)
            run_duty(duty_tab[i], duty_exp[i]);
        delay = 16'h0003;
        run_duty(16'h000a, 16'h000a);
        wait_on(0, 400, n);
        wait_on(1, 100, n);
        check_val("sample_at", 16'h0009, n);
        check_val("cur_fb", 12'h123, cur_o);
        ref_set = 12'h100;
        gap = 12'h010;
        cur_raw = 12'h110;
        run_duty(16'h000a, 16'h000a);
        cur_raw = 12'h111;
        run_duty(16'h000a, 16'h0000);
        wait_on(0, 400, n);
        wait_on(1, 100, n);
        check_val("blank_sample_at", 16'h000b, n);
        ref_set = 12'h800;
        shutdown = 1'b1;
        run_duty(16'h000a, 16'h0000);
        check_val("active", 1'b0, active);
        shutdown = 1'b0;
        enable = 1'b0;
        run_duty(16'h000a, 16'h0000);
        check_val("active", 1'b0, active);
        enable = 1'b1;
        tick(2);
        check_val("active", 1'b1, active);
        ac_raw = 13'h1e00;
        repeat (2) wait_on(0, 400, n);
        check_val("ac_fb", 12'h200, acv);
        ac_raw = 13'h0180;
        repeat (2) wait_on(0, 400, n);
        check_val("ac_fb", 12'h180, acv);
        ac_raw = 13'h0200;
        offset = 12'h100;
        tick(130);
        check_val("blank", 1'b0, blank);
        check_val("bus_fb", 12'h300, bus_o);
        offset = 12'h101;
        wait_on(2, 200, n);
        check_val("blank_within", 1'b1, n <= 61);
        offset = 12'h000;
        wait_on(3, 400, n);
        check_val("blank_len", 1'b1, n >= 100 && n <= 165);
        ov_lvl = 12'h100;
        wait_on(4, 1000, n);
        check_val("over_time", 1'b1, n >= 50 && acw[2]);
        tick(1);
        check_val("fault", 1'b1, acw[0]);
        check_val("peak", 12'h200, peak);
        second = 16'h0000;
        tick(2);
        check_val("active", 1'b0, active);
        second = 16'h0100;
        tick(2);
        check_val("active", 1'b1, active);
        ov_lvl = 12'hfff;
        wait_on(6, 1000, n);
        check_val("recover", 1'b1, n >= 40 && acw == 3'h0);
        uv_lvl = 12'h300;
        wait_on(5, 1000, n);
        check_val("under_time", 1'b1, n >= 50 && acw[1]);
        report_and_stop();
    end
endmodule
